// *** inc/adc_result_defines.vh ***
`ifndef ADC_RESULT_DEFINES_VH
`define ADC_RESULT_DEFINES_VH
`define SEL_CTRL 4'h3
`define SEL_STAT2 4'h5
`define SEL_V_LO 4'h8
`define SEL_V_HI 4'h9
`define SEL_I_LO 4'ha
`define SEL_I_HI 4'hb
`define SEL_T_LO 4'hc
`define SEL_T_HI 4'hd
`define SEL_IRQ_STAT 4'he
`define SEL_IRQ_MASK 4'hf
`define CTRL_START_BIT 3
`define CTRL_ABORT_BIT 2
`define STAT2_BUSY_BIT 3
`define DONE_BIT 7
`define REG_RESET 8'h00
`define RESULT_RESET 15'h0000
`define Q_VOLT 2'h0
`define Q_CURR 2'h1
`define Q_TEMP 2'h2
`endif

// *** hw/result_slot.v ***
`timescale 1ns/1ps
`include "adc_result_defines.vh"
module result_slot (
  clk_sys,
  rst_n,
  ce,
  start,
  done,
  result,
  value_ff,
  complete_ff
);
  input wire clk_sys;
  input wire rst_n;
  input wire ce;
  input wire start;
  input wire done;
  input wire [14:0] result;
  output reg [14:0] value_ff;
  output reg complete_ff;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value_ff <= `RESULT_RESET;
      complete_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (done)
      begin
        value_ff <= result;
        complete_ff <= 1'b1;
      end
      else if (start)
        complete_ff <= 1'b0;
    end
  end
endmodule // result_slot

// *** hw/port_adc_result_registers.v ***
// Summary of operation
// - select 1000 reads voltage bits 7..0
// - select 1001 reads voltage bits 14..8
// - voltage done flag clears at start
// - voltage done flag sets at finish
// - select 1010 reads current bits 7..0
// - select 1011 reads current bits 14..8
// - current done flag clears at start
// - current done flag sets at finish
// - select 1100 reads temperature bits 7..0
// - select 1101 reads temperature bits 14..8
// - temperature done flag clears at start
// - temperature done flag sets at finish
// - control bit 3 starts, self clears
// - status 2 bit 3 shows busy
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "adc_result_defines.vh"
module port_adc_result_registers (
  clk_sys,
  rst_n,
  ce,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  conv_start,
  conv_abort,
  conv_sel,
  adc_begin,
  adc_done,
  adc_result,
  irq
);
  input wire clk_sys;
  input wire rst_n;
  input wire ce;
  input wire [3:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [7:0] reg_rdata;
  output reg conv_start;
  output reg conv_abort;
  output reg [1:0] conv_sel;
  input wire adc_begin;
  input wire adc_done;
  input wire [14:0] adc_result;
  output wire irq;

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  reg state_ff;
  reg nxt_state;
  reg [1:0] qsel_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_mask_ff;
  reg [2:0] nxt_irq_stat;
  wire [14:0] volt_val;
  wire [14:0] curr_val;
  wire [14:0] temp_val;
  wire volt_ok;
  wire curr_ok;
  wire temp_ok;
  wire start_wr;
  wire start_ok;
  wire abort_wr;
  wire stat_wr;
  wire mask_wr;
  reg [2:0] begin_vec;
  reg [2:0] done_vec;
  reg nxt_conv_start;
  reg nxt_conv_abort;
  reg [7:0] nxt_rdata;
  wire [7:0] volt_lo_word;
  wire [7:0] volt_hi_word;
  wire [7:0] curr_lo_word;
  wire [7:0] curr_hi_word;
  wire [7:0] temp_lo_word;
  wire [7:0] temp_hi_word;

  function [2:0] onehot;
    input [1:0] q;
    begin
      onehot = 3'h0;
      case (q)
        `Q_VOLT: onehot = 3'h1;
        `Q_CURR: onehot = 3'h2;
        `Q_TEMP: onehot = 3'h4;
        default: onehot = 3'h0;
      endcase
    end
  endfunction

  function [7:0] hi_byte;
    input ok;
    input [14:0] v;
    begin
      hi_byte = {ok, v[14:8]};
    end
  endfunction

  // read mux, zero for unmapped selects
  function [7:0] rd_word;
    input [3:0] sel;
    begin
      rd_word = `REG_RESET;
      case (sel)
        `SEL_CTRL: rd_word = {6'h00, qsel_ff};
        `SEL_STAT2: rd_word = {4'h0, state_ff == ST_BUSY, 3'h0};
        `SEL_V_LO: rd_word = volt_lo_word;
        `SEL_V_HI: rd_word = volt_hi_word;
        `SEL_I_LO: rd_word = curr_lo_word;
        `SEL_I_HI: rd_word = curr_hi_word;
        `SEL_T_LO: rd_word = temp_lo_word;
        `SEL_T_HI: rd_word = temp_hi_word;
        `SEL_IRQ_STAT: rd_word = {5'h00, irq_stat_ff};
        `SEL_IRQ_MASK: rd_word = {5'h00, irq_mask_ff};
        default: rd_word = `REG_RESET;
      endcase
    end
  endfunction

  assign volt_lo_word = volt_val[7:0];
  assign volt_hi_word = hi_byte(volt_ok, volt_val);
  assign curr_lo_word = curr_val[7:0];
  assign curr_hi_word = hi_byte(curr_ok, curr_val);
  assign temp_lo_word = temp_val[7:0];
  assign temp_hi_word = hi_byte(temp_ok, temp_val);

  assign start_wr = reg_wr && (reg_addr == `SEL_CTRL) && reg_wdata[`CTRL_START_BIT];
  assign start_ok = start_wr && (state_ff == ST_IDLE);
  assign abort_wr = reg_wr && (reg_addr == `SEL_CTRL) && reg_wdata[`CTRL_ABORT_BIT];
  assign stat_wr = reg_wr && (reg_addr == `SEL_IRQ_STAT);
  assign mask_wr = reg_wr && (reg_addr == `SEL_IRQ_MASK);

  // converter events count only while busy
  always @*
  begin
    begin_vec = 3'h0;
    if (state_ff == ST_BUSY && adc_begin)
    begin
      begin_vec = onehot(qsel_ff);
    end
  end

  always @*
  begin
    done_vec = 3'h0;
    if (state_ff == ST_BUSY && adc_done)
    begin
      done_vec = onehot(qsel_ff);
    end
  end

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (start_wr) nxt_state = ST_BUSY;
      ST_BUSY: if (adc_done || conv_abort) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @*
  begin
    nxt_irq_stat = irq_stat_ff;
    if (stat_wr)
      nxt_irq_stat = irq_stat_ff & ~reg_wdata[2:0];
    nxt_irq_stat = nxt_irq_stat | done_vec;
  end

  // start bit is a one-cycle pulse, never stored
  always @*
  begin
    nxt_conv_start = 1'b0;
    if (start_ok)
    begin
      nxt_conv_start = 1'b1;
    end
  end

  // abort only means something while busy
  always @*
  begin
    nxt_conv_abort = 1'b0;
    if (abort_wr && state_ff == ST_BUSY)
    begin
      nxt_conv_abort = 1'b1;
    end
  end

  // read data stands one cycle, else zero
  always @*
  begin
    nxt_rdata = `REG_RESET;
    if (reg_rd)
    begin
      nxt_rdata = rd_word(reg_addr);
    end
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= ST_IDLE;
    else if (ce)
      state_ff <= nxt_state;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      conv_start <= 1'b0;
    else if (ce)
      conv_start <= nxt_conv_start;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      conv_abort <= 1'b0;
    else if (ce)
      conv_abort <= nxt_conv_abort;
  end

  // quantity latched only on an accepted start
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      qsel_ff <= `Q_VOLT;
      conv_sel <= `Q_VOLT;
    end
    else if (ce)
    begin
      if (start_ok)
      begin
        qsel_ff <= reg_wdata[1:0];
        conv_sel <= reg_wdata[1:0];
      end
    end
  end

  // set wins over write-one-to-clear
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat_ff <= 3'h0;
    else if (ce)
      irq_stat_ff <= nxt_irq_stat;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_ff <= 3'h0;
    else if (ce)
    begin
      if (mask_wr)
      begin
        irq_mask_ff <= reg_wdata[2:0];
      end
    end
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= `REG_RESET;
    else if (ce)
      reg_rdata <= nxt_rdata;
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  result_slot u_volt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .start(begin_vec[0]),
    .done(done_vec[0]),
    .result(adc_result),
    .value_ff(volt_val),
    .complete_ff(volt_ok)
  );

  result_slot u_curr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .start(begin_vec[1]),
    .done(done_vec[1]),
    .result(adc_result),
    .value_ff(curr_val),
    .complete_ff(curr_ok)
  );

  result_slot u_temp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .start(begin_vec[2]),
    .done(done_vec[2]),
    .result(adc_result),
    .value_ff(temp_val),
    .complete_ff(temp_ok)
  );
endmodule // port_adc_result_registers

// *** bench/adc_result_properties.sv ***
`timescale 1ns/1ps
module adc_result_properties (
  input wire clk_sys,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire conv_start,
  input wire [1:0] conv_sel,
  input wire adc_begin,
  input wire adc_done,
  input wire [14:0] adc_result,
  input wire irq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_start_one_cycle: assert property (conv_start |=> !conv_start) else $error("long start");
  a_start_from_write: assert property (conv_start |-> $past(reg_wr) && $past(reg_addr) == 4'h3
    && $past(reg_wdata[3])) else $error("stray start");
  a_sel_from_write: assert property (conv_start |-> conv_sel == $past(reg_wdata[1:0]))
    else $error("bad sel");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata");
  a_flag_clear_begin: assert property (adc_begin ##2 reg_rd && reg_addr == 9 + 2 * conv_sel
    |=> !reg_rdata[7]) else $error("flag stuck");
  a_high_byte_done: assert property (adc_done ##2 reg_rd && reg_addr == 9 + 2 * conv_sel
    |=> reg_rdata == {1'b1, $past(adc_result[14:8], 3)}) else $error("high byte");
  a_low_byte_done: assert property (adc_done ##4 reg_rd && reg_addr == 8 + 2 * conv_sel
    |=> reg_rdata == $past(adc_result[7:0], 5)) else $error("low byte");
  a_irq_from_done: assert property ($rose(irq) |-> $past(adc_done)) else $error("irq");
  cover property (conv_start);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule // adc_result_properties

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  reg clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, adc_begin = 0, adc_done = 0;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg [14:0] adc_result = 15'h0000;
  reg [14:0] v;
  reg [1:0] q;
  reg [14:0] last [0:2];
  wire [7:0] reg_rdata;
  wire [1:0] conv_sel;
  wire conv_start, conv_abort, irq;
  integer i, miscompares = 0, checks_done = 0;
  port_adc_result_registers dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(1'b1),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .conv_start(conv_start),
    .conv_abort(conv_abort),
    .conv_sel(conv_sel),
    .adc_begin(adc_begin),
    .adc_done(adc_done),
    .adc_result(adc_result),
    .irq(irq)
  );
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  task print_verdict;
  begin
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  task ck(input [7:0] e, input [7:0] g);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  end
  endtask
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
  end
  endtask
  task rc(input [3:0] a, input [7:0] e);
  begin
    @(posedge clk_sys);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 ck(e, reg_rdata);
  end
  endtask
  task pulse(input b);
  begin
    @(posedge clk_sys);
    adc_begin <= b;
    adc_done <= !b;
    @(posedge clk_sys);
    adc_begin <= 0;
    adc_done <= 0;
  end
  endtask
  initial
  begin
    for (i = 0; i < 3; i = i + 1)
      last[i] = 15'h0000;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1;
    for (i = 8; i < 14; i = i + 1)
      rc(i[3:0], 8'h00);
    rc(4'h6, 8'h00);
    wr(4'hf, 8'h07);
    for (i = 0; i < 4; i = i + 1)
    begin
      q = i % 3;
      v = 15'h4c81 ^ {i[2:0], 12'h5a3};
      wr(4'h3, {6'h02, q});
      rc(4'h5, 8'h08);
      pulse(1);
      rc({1'b1, q, 1'b1}, {1'b0, last[q][14:8]});
      last[q] = v;
      adc_result <= v;
      pulse(0);
      rc({1'b1, q, 1'b1}, {1'b1, v[14:8]});
      rc({1'b1, q, 1'b0}, v[7:0]);
      rc(4'h5, 8'h00);
      ck(8'h01, {7'h00, irq});
      rc(4'he, 8'h01 << q);
      wr(4'hf, 8'h00);
      #1 ck(8'h00, {7'h00, irq});
      wr(4'he, 8'h01 << q);
      rc(4'he, 8'h00);
      wr(4'hf, 8'h07);
      #1 ck(8'h00, {7'h00, irq});
    end
    wr(4'h8, 8'hff);
    rc(4'h8, v[7:0]);
    wr(4'h3, 8'h09);
    rc(4'h5, 8'h08);
    wr(4'h3, 8'h04);
    #1 ck(8'h01, {7'h00, conv_abort});
    rc(4'h5, 8'h00);
    rc(4'hb, {1'b1, last[1][14:8]});
    print_verdict;
  end
  initial
  begin
    #100000;
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule // tb_top
bind port_adc_result_registers adc_result_properties chk (.*);
